// File: dv/ews_mem_model.sv
// Slow static memory that stretches accesses with an active-low wait.
// Assumes registered active-low strobes from the sequencer on clk.
`timescale 1ns/1ns
module ews_mem_model
(
  input  logic        clk,
  input  logic        chip_select_n,
  input  logic        read_strobe_n,
  input  logic        write_strobe_n,
  input  logic [23:0] ext_addr,
  input  logic [15:0] data_out,
  input  logic        data_oe_n,
  input  logic [3:0]  stall_at,
  input  logic [3:0]  stall_len,
  output logic        wait_request_n,
  output logic [15:0] data_in,
  output logic [31:0] wr_word
);
  logic [4:0]  cyc_q = 5'h00;
  logic        tog_q = 1'b0;
  logic [15:0] pat;

  // Plain always: these registers carry declaration initialisers
  always @(posedge clk)
  begin
    tog_q <= ~tog_q;
    cyc_q <= chip_select_n ? 5'h00 : cyc_q + 5'h01;
  end

  // Wait window in cycles since select; the bench may place it too late
  assign wait_request_n = chip_select_n || !(cyc_q >= {1'b0, stall_at} &&
    cyc_q < {1'b0, stall_at} + {1'b0, stall_len});

  // Data is not yet valid while waiting; a released bus keeps changing
  assign pat     = ext_addr[15:0] ^ 16'h5a3c;
  assign data_in = read_strobe_n ? {8{tog_q, ~tog_q}} :
                   (wait_request_n ? pat : ~pat);

  always_ff @(posedge clk)
  begin
    if (!write_strobe_n && !data_oe_n && ext_addr[1])
      wr_word[31:16] <= data_out;
    if (!write_strobe_n && !data_oe_n && !ext_addr[1])
      wr_word[15:0] <= data_out;
  end
endmodule : ews_mem_model

// File: dv/ews_seq_tb_top.sv
// Self-checking bench for the wait-stretching access sequencer.
// Assumes the memory model answers on the external side.
`timescale 1ns/1ns
module ews_seq_tb_top;
  import ews_pkg::*;
  logic        clk;
  logic        nrst;
  logic        req;
  logic        req_write;
  ews_width_t  req_width;
  logic [23:0] req_addr;
  logic [31:0] req_wdata;
  logic [3:0]  std_wait_states;
  logic [3:0]  stall_at;
  logic [3:0]  stall_len;
  logic        wait_request_n;
  logic [15:0] data_in;
  logic [15:0] data_out;
  logic        data_oe_n;
  logic [23:0] ext_addr;
  logic        chip_select_n;
  logic        read_strobe_n;
  logic        write_strobe_n;
  logic [31:0] rdata;
  logic [31:0] wr_word;
  logic        done;
  logic        busy;
  logic [31:0] cs_len;
  logic [31:0] st_len;
  int          err_count;
  int          check_count;

  ews_seq DUT (.clk(clk), .nrst(nrst), .req(req), .req_write(req_write),
    .req_width(req_width), .req_addr(req_addr), .req_wdata(req_wdata),
    .std_wait_states(std_wait_states), .wait_request_n(wait_request_n),
    .data_in(data_in), .data_out(data_out), .data_oe_n(data_oe_n),
    .ext_addr(ext_addr), .chip_select_n(chip_select_n),
    .read_strobe_n(read_strobe_n), .write_strobe_n(write_strobe_n),
    .rdata(rdata), .done(done), .busy(busy));

  ews_mem_model mem (.clk(clk), .chip_select_n(chip_select_n),
    .read_strobe_n(read_strobe_n), .write_strobe_n(write_strobe_n),
    .ext_addr(ext_addr), .data_out(data_out), .data_oe_n(data_oe_n),
    .stall_at(stall_at), .stall_len(stall_len),
    .wait_request_n(wait_request_n), .data_in(data_in), .wr_word(wr_word));

  initial
  begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end

  // Select and strobe lengths of the access in flight
  always @(posedge clk)
  begin
    cs_len <= (req && !busy) ? 0 : cs_len + 32'(!chip_select_n);
    st_len <= (req && !busy) ? 0 :
              st_len + 32'(!read_strobe_n || !write_strobe_n);
  end

  function automatic logic [15:0] pat(input logic [23:0] a);
    return a[15:0] ^ 16'h5a3c;
  endfunction : pat

  task automatic print_verdict;
    if (err_count == 0 && check_count > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask : print_verdict

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    check_count++;
    if (seen !== exp)
    begin
      err_count++;
      $display("CHECK FAILED %0t: saw %h want %h", $time, seen, exp);
    end
  endtask : check

  task automatic access(input logic wr, input ews_width_t w,
    input logic [3:0] n, input logic [3:0] at, input logic [3:0] len,
    input logic [23:0] a, input logic [31:0] d, input int ecs, input int est);
    int k;
    @(posedge clk);
    req             <= 1'b1;
    req_write       <= wr;
    req_width       <= w;
    req_addr        <= a;
    req_wdata       <= d;
    std_wait_states <= n;
    stall_at        <= at;
    stall_len       <= len;
    @(posedge clk);
    req <= 1'b0;
    for (k = 0; k < 200 && done !== 1'b1; k++)
    begin
      @(posedge clk);
      #1;
    end
    if (done !== 1'b1)
    begin
      err_count++;
      print_verdict();
    end
    check(cs_len, ecs);
    check(st_len, est);
    @(posedge clk);
    #1;
    check({30'h0, done, busy}, 32'h0);
  endtask : access

  task automatic sc_wait_at_start;
    access(1'b1, EWS_W16, 4'h2, 4'h0, 4'h2, 24'h000100, 32'h0000beef, 5, 5);
    check(32'(wr_word[15:0]), 32'h0000beef);
  endtask : sc_wait_at_start

  task automatic sc_wait_in_std;
    access(1'b0, EWS_W32, 4'h2, 4'h1, 4'h3, 24'h001230, 32'h0, 10, 9);
    check(rdata, {pat(24'h001232), pat(24'h001230)});
  endtask : sc_wait_in_std

  task automatic sc_late_read32;
    access(1'b0, EWS_W32, 4'h1, 4'h1, 4'h2, 24'h001230, 32'h0, 7, 6);
    check(32'(rdata[15:0]), {16'h0, ~pat(24'h001230)});
    check(32'(rdata[31:16]), 32'(pat(24'h001232)));
  endtask : sc_late_read32

  task automatic sc_late_narrow;
    access(1'b0, EWS_W16, 4'h1, 4'h1, 4'h2, 24'h004420, 32'h0, 4, 4);
    check(rdata, 32'(pat(24'h004420)));
    access(1'b0, EWS_W8, 4'h1, 4'h0, 4'h0, 24'h000051, 32'h0, 2, 2);
    check(rdata, {16'h0, pat(24'h000051) & 16'h00ff});
  endtask : sc_late_narrow

  task automatic sc_late_write;
    access(1'b1, EWS_W32, 4'h2, 4'h2, 4'h2, 24'h000200, 32'h1234abcd, 9, 6);
    check(wr_word, 32'h1234abcd);
    access(1'b1, EWS_W16, 4'h2, 4'h2, 4'h2, 24'h000300, 32'h00005a5a, 5, 3);
    check(32'(wr_word[15:0]), 32'h00005a5a);
  endtask : sc_late_write

  initial
  begin
    err_count       = 0;
    check_count     = 0;
    nrst            = 1'b0;
    req             = 1'b0;
    req_write       = 1'b0;
    req_width       = EWS_W16;
    req_addr        = 24'h000000;
    req_wdata       = 32'h00000000;
    std_wait_states = 4'h2;
    stall_at        = 4'h0;
    stall_len       = 4'h0;
    repeat (5) @(posedge clk);
    nrst <= 1'b1;
    repeat (3) @(posedge clk);
    sc_wait_at_start();
    sc_wait_in_std();
    sc_late_read32();
    sc_late_narrow();
    sc_late_write();
    print_verdict();
  end
endmodule : ews_seq_tb_top

// File: include/ews_cfg.svh
// Constants for the external bus wait-extension sequencer.
// Assumes a 16-bit external data bus and a single master clock.
`ifndef EWS_CFG_SVH
`define EWS_CFG_SVH
`define EWS_CLK_PERIOD_NS 10
`define EWS_DATA_W        32
`define EWS_HALF_W        16
`define EWS_BYTE_W        8
`define EWS_ADDR_W        24
`define EWS_WS_W          4
`define EWS_HALF_SEL_BIT  1
`define EWS_MIN_WS_NARROW 1
`define EWS_MIN_WS_WIDE   2
`define EWS_IDLE_HALF     16'h0000
`endif

// File: include/ews_pkg.sv
// Types for the external bus wait-extension sequencer.
// Shared by the sequencer and its bench.
package ews_pkg;
  typedef enum logic [2:0]
  {
    EWS_ST_IDLE = 3'b001,
    EWS_ST_ACC  = 3'b010,
    EWS_ST_GAP  = 3'b100
  } ews_state_t;

  typedef enum logic [1:0]
  {
    EWS_W8  = 2'h0,
    EWS_W16 = 2'h1,
    EWS_W32 = 2'h2
  } ews_width_t;
endpackage : ews_pkg

// File: logic/ews_rst_sync.sv
// Reset release synchroniser: asserts at once, releases after two edges.
// Assumes nrst may be asynchronous to clk.
`timescale 1ns/1ns
module ews_rst_sync
(
  input  logic clk,
  input  logic nrst,
  output logic rst_n_sync
);
  logic meta_q;

  always_ff @(posedge clk or negedge nrst)
  begin
    if (!nrst)
    begin
      meta_q     <= 1'b0;
      rst_n_sync <= 1'b0;
    end
    else
    begin
      meta_q     <= 1'b1;
      rst_n_sync <= meta_q;
    end
  end
endmodule : ews_rst_sync

// File: logic/ews_seq.sv
// External static memory access sequencer with wait request stretching.
// Assumes wait_request_n is synchronous to clk; 16-bit external data bus.
`timescale 1ns/1ns
`include "ews_cfg.svh"
module ews_seq
#(
  parameter int WS_W   = `EWS_WS_W,
  parameter int ADDR_W = `EWS_ADDR_W
)
(
  input  logic                       clk,
  input  logic                       nrst,
  input  logic                       req,
  input  logic                       req_write,
  input  ews_pkg::ews_width_t        req_width,
  input  logic [ADDR_W-1:0]          req_addr,
  input  logic [`EWS_DATA_W-1:0]     req_wdata,
  input  logic [WS_W-1:0]            std_wait_states,
  input  logic                       wait_request_n,
  input  logic [`EWS_HALF_W-1:0]     data_in,
  output logic [`EWS_HALF_W-1:0]     data_out,
  output logic                       data_oe_n,
  output logic [ADDR_W-1:0]          ext_addr,
  output logic                       chip_select_n,
  output logic                       read_strobe_n,
  output logic                       write_strobe_n,
  output logic [`EWS_DATA_W-1:0]     rdata,
  output logic                       done,
  output logic                       busy
);
  import ews_pkg::*;

  if (WS_W < 1 || ADDR_W < 2)
  begin : g_chk
    $error("ews_seq: WS_W must be >= 1 and ADDR_W >= 2");
  end

  logic            rst_n;
  ews_state_t      state_q;
  logic [WS_W-1:0] cnt_q;
  logic [WS_W-1:0] nws_q;
  logic            wr_q;
  ews_width_t      wid_q;
  logic            half_q;
  logic            early_q;
  logic            late_q;
  logic [`EWS_DATA_W-1:0] wdata_q;

  ews_rst_sync u_rst_sync
  (
    .clk        (clk),
    .nrst       (nrst),
    .rst_n_sync (rst_n)
  );

  logic start;
  logic in_acc;
  logic waiting;
  logic last;
  logic stall;
  logic early_ev;
  logic late_ev;
  logic half_end;
  logic final_end;
  logic wide;
  logic [`EWS_HALF_W-1:0] din_masked;

  assign start     = req && (state_q == EWS_ST_IDLE);
  assign in_acc    = (state_q == EWS_ST_ACC);
  assign waiting   = !wait_request_n;
  assign last      = (cnt_q == nws_q);
  assign stall     = in_acc && waiting;
  // A wait seen at the first edge or with standard states left is honoured
  assign early_ev  = stall && (!last || cnt_q == '0) && !late_q;
  assign late_ev   = stall && last && cnt_q != '0 && !early_q && !late_q;
  assign half_end  = in_acc && !waiting && last;
  assign wide      = (wid_q == EWS_W32);
  assign final_end = half_end && !(wide && !half_q);
  assign din_masked = (wid_q == EWS_W8) ?
                      {{(`EWS_HALF_W-`EWS_BYTE_W){1'b0}},
                       data_in[`EWS_BYTE_W-1:0]} : data_in;

  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
      state_q <= EWS_ST_IDLE;
    else
    begin
      case (state_q)
        EWS_ST_IDLE:
          if (start)
            state_q <= EWS_ST_ACC;
        EWS_ST_ACC:
          if (half_end)
            state_q <= final_end ? EWS_ST_IDLE : EWS_ST_GAP;
        EWS_ST_GAP:
          state_q <= EWS_ST_ACC;
        default:
          state_q <= EWS_ST_IDLE;
      endcase
    end
  end

  // Standard wait-state counter freezes while the request holds the bus
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
      cnt_q <= '0;
    else if (start || state_q == EWS_ST_GAP)
      cnt_q <= '0;
    else if (in_acc && !waiting && !last)
      cnt_q <= cnt_q + 1'b1;
  end

  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      nws_q   <= '0;
      wr_q    <= 1'b0;
      wid_q   <= EWS_W8;
      wdata_q <= '0;
    end
    else if (start)
    begin
      nws_q   <= std_wait_states;
      wr_q    <= req_write;
      wid_q   <= req_width;
      wdata_q <= req_wdata;
    end
  end

  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
      half_q <= 1'b0;
    else if (start)
      half_q <= 1'b0;
    else if (half_end && !final_end)
      half_q <= 1'b1;
  end

  // Early and late wait classification, fresh for each 16-bit half
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      early_q <= 1'b0;
      late_q  <= 1'b0;
    end
    else if (start || state_q == EWS_ST_GAP)
    begin
      early_q <= 1'b0;
      late_q  <= 1'b0;
    end
    else
    begin
      if (early_ev)
        early_q <= 1'b1;
      if (late_ev)
        late_q <= 1'b1;
    end
  end

  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
      chip_select_n <= 1'b1;
    else if (start)
      chip_select_n <= 1'b0;
    else if (final_end)
      chip_select_n <= 1'b1;
  end

  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
      read_strobe_n <= 1'b1;
    else if ((start && !req_write) || (state_q == EWS_ST_GAP && !wr_q))
      read_strobe_n <= 1'b0;
    else if (half_end)
      read_strobe_n <= 1'b1;
  end

  // A late request cannot stretch the write pulse, only the access
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
      write_strobe_n <= 1'b1;
    else if ((start && req_write) || (state_q == EWS_ST_GAP && wr_q))
      write_strobe_n <= 1'b0;
    else if (half_end || (late_ev && wr_q))
      write_strobe_n <= 1'b1;
  end

  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      ext_addr  <= '0;
      data_out  <= `EWS_IDLE_HALF;
      data_oe_n <= 1'b1;
    end
    else if (start)
    begin
      ext_addr  <= req_addr;
      data_out  <= req_wdata[`EWS_HALF_W-1:0];
      data_oe_n <= !req_write;
    end
    else if (half_end && !final_end)
    begin
      ext_addr[`EWS_HALF_SEL_BIT] <= 1'b1;
      data_out  <= wdata_q[`EWS_DATA_W-1:`EWS_HALF_W];
    end
    else if (final_end)
      data_oe_n <= 1'b1;
  end

  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
      rdata <= '0;
    else if (start && !req_write)
      rdata <= '0;
    else if (late_ev && !wr_q && wide && !half_q)
      rdata[`EWS_HALF_W-1:0] <= data_in;
    else if (half_end && !wr_q)
    begin
      if (half_q)
        rdata[`EWS_DATA_W-1:`EWS_HALF_W] <= data_in;
      else if (!(wide && late_q))
        rdata[`EWS_HALF_W-1:0] <= din_masked;
    end
  end

  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      done <= 1'b0;
      busy <= 1'b0;
    end
    else
    begin
      done <= final_end;
      if (start)
        busy <= 1'b1;
      else if (final_end)
        busy <= 1'b0;
    end
  end

  AST_EARLY_HOLD: assert property (@(posedge clk)
    disable iff (!rst_n)
    early_ev |=> !chip_select_n && in_acc && $stable(cnt_q))
    else $error("early wait did not hold the access");
  AST_EARLY_WRITE: assert property (@(posedge clk)
    disable iff (!rst_n) (early_ev && wr_q) |=> !write_strobe_n)
    else $error("early wait did not stretch write strobe");
  AST_LATE_FIRST_HALF: assert property (@(posedge clk)
    disable iff (!rst_n) (late_ev && !wr_q && wide && !half_q) |=>
      rdata[`EWS_HALF_W-1:0] == $past(data_in))
    else $error("late 32-bit read first half not taken at standard end");
  AST_LATE_READ_STROBE: assert property (@(posedge clk)
    disable iff (!rst_n) (stall && !wr_q) |=> !read_strobe_n)
    else $error("read strobe not stretched by wait");
  AST_LATE_WRITE_REL: assert property (@(posedge clk)
    disable iff (!rst_n)
    (late_ev && wr_q) |=> write_strobe_n ##1 write_strobe_n)
    else $error("write strobe not released at last standard cycle");
  AST_LATE_CS_HOLD: assert property (@(posedge clk)
    disable iff (!rst_n) (late_q && stall) |=> !chip_select_n)
    else $error("chip select released while wait active");
  AST_RELEASE_END: assert property (@(posedge clk)
    disable iff (!rst_n)
    final_end |=> chip_select_n && done && read_strobe_n && write_strobe_n
      ##1 !done)
    else $error("access did not complete after wait withdrawn");
  AST_COUNT_ADVANCE: assert property (@(posedge clk)
    disable iff (!rst_n)
    (in_acc && !waiting && !last) |=> cnt_q == $past(cnt_q) + 1'b1)
    else $error("wait-state counter did not advance");

  COV_EARLY: cover property (@(posedge clk) disable iff (!rst_n)
    early_ev ##[1:20] final_end);
  COV_LATE_WRITE: cover property (@(posedge clk) disable iff (!rst_n)
    (late_ev && wr_q) ##[1:20] final_end);
  COV_LATE_READ32: cover property (@(posedge clk) disable iff (!rst_n)
    (late_ev && wide && !wr_q) ##[1:40] final_end);
endmodule : ews_seq
